// >>> src/gp_cfg.svh
`ifndef GP_CFG_SVH
`define GP_CFG_SVH

// Port geometry
`define GP_PORT_WIDTH      8

// Register byte offsets
`define GP_OFF_DIR         8'h00
`define GP_OFF_OUT         8'h04
`define GP_OFF_PIN         8'h08
`define GP_OFF_CTRL        8'h0c

// Control register field positions
`define GP_CTRL_PUD_BIT    0

// Reset values
`define GP_DIR_RST         8'h00
`define GP_OUT_RST         8'h00
`define GP_PUD_RST         1'b0
`define GP_RDATA_RST       32'h0000_0000

// AHB encodings
`define GP_HTRANS_NONSEQ_BIT 1
`define GP_HRESP_OKAY      1'b0

`endif

// >>> src/gp_pkg.sv
`default_nettype none

`include "gp_cfg.svh"

package gp_pkg;

    typedef enum logic [2:0] {
        GP_SEL_NONE,
        GP_SEL_DIR,
        GP_SEL_OUT,
        GP_SEL_PIN,
        GP_SEL_CTRL
    } gp_sel_t;

    // Register select from a byte address
    function automatic gp_sel_t gp_decode(input logic [31:0] addr);
        gp_sel_t sel;
        sel = GP_SEL_NONE;
        case (addr[7:0])
            `GP_OFF_DIR:  sel = GP_SEL_DIR;
            `GP_OFF_OUT:  sel = GP_SEL_OUT;
            `GP_OFF_PIN:  sel = GP_SEL_PIN;
            `GP_OFF_CTRL: sel = GP_SEL_CTRL;
            default:      sel = GP_SEL_NONE;
        endcase
        return sel;
    endfunction : gp_decode

endpackage : gp_pkg

`default_nettype wire

// >>> src/gp_port.sv
// Functional notes
// (RULE1) Direction one drives, zero listens
// (RULE2) Input with data one enables pull-up
// (RULE3) Global disable kills every pull-up
// (RULE4) Reset tri-states pins without clock
// (RULE5) Output drives the output-data level
// (RULE6) Writing one to input bit toggles data
// (RULE7) Synchronized level readable in any direction
// (RULE8) Half-cycle latch then rising-edge flop
// (RULE9) Pin change seen after half to 1.5 cycles
// (RULE10) Written level reaches input register next cycle
// (RULE11) Software idles once before reading back
// (RULE12) Software steps through 01 or 10
// (RULE13) Software steps through 00 or 11
// (RULE14) Sleep clamp grounds digital inputs
// (RULE15) Enabled external interrupt escapes the clamp
// (RULE16) Alternate functions may escape the clamp
// (RULE17) Clamp release yields edge on wake
// (RULE18) Pull-ups off during reset
// (RULE19) Strobes per port, clamp and disable shared
// (RULE20) Three registers: direction, data, input; the code adds a fourth, the control register at 0x0c
// (RULE21) Input register read-only, writes toggle
// (RULE22) Eight pins, single-cycle register access
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none

`include "gp_cfg.svh"

module gp_port
    import gp_pkg::*;
#(
    parameter int WIDTH = `GP_PORT_WIDTH
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] pullup_en,
    input  wire logic             sleep_clamp,
    input  wire logic [WIDTH-1:0] ext_int_enable,
    input  wire logic [WIDTH-1:0] alt_input_enable,
    output logic      [WIDTH-1:0] pin_level,
    output logic                  global_pullup_disable
);

    // Register state
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] out_data_reg;
    logic [WIDTH-1:0] out_data_next;
    logic             pud_reg;
    logic             pud_next;

    // Input synchronizer
    logic [WIDTH-1:0] digital_in;
    logic [WIDTH-1:0] sync_latch_reg;
    logic [WIDTH-1:0] sync_latch_next;
    logic [WIDTH-1:0] pin_input_reg;
    logic [WIDTH-1:0] pin_input_next;

    // Bus state
    logic             wr_pend_reg;
    logic             wr_pend_next;
    gp_sel_t          wr_sel_reg;
    gp_sel_t          wr_sel_next;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;

    // Decoded access
    logic             addr_phase;
    gp_sel_t          ap_sel;
    logic [WIDTH-1:0] wdata;

    // Per-port strobes
    logic             dir_reg_write_strobe;
    logic             out_reg_write_strobe;
    logic             in_reg_write_strobe;
    logic             ctrl_write_strobe;
    logic             dir_reg_read_strobe;
    logic             out_reg_read_strobe;
    logic             pin_read_strobe;
    logic             ctrl_read_strobe;

    // Address phase decode
    always_comb begin
        addr_phase = hsel & hready & htrans[`GP_HTRANS_NONSEQ_BIT];
        ap_sel     = gp_decode(haddr);
        wdata      = hwdata[WIDTH-1:0];
    end

    // Strobes shared by all pins of the port
    always_comb begin
        dir_reg_write_strobe = wr_pend_reg & (wr_sel_reg == GP_SEL_DIR); // RULE19
        out_reg_write_strobe = wr_pend_reg & (wr_sel_reg == GP_SEL_OUT); // RULE19
        in_reg_write_strobe  = wr_pend_reg & (wr_sel_reg == GP_SEL_PIN); // RULE19
        ctrl_write_strobe    = wr_pend_reg & (wr_sel_reg == GP_SEL_CTRL);
        dir_reg_read_strobe  = addr_phase & ~hwrite & (ap_sel == GP_SEL_DIR);
        out_reg_read_strobe  = addr_phase & ~hwrite & (ap_sel == GP_SEL_OUT);
        pin_read_strobe      = addr_phase & ~hwrite & (ap_sel == GP_SEL_PIN);
        ctrl_read_strobe     = addr_phase & ~hwrite & (ap_sel == GP_SEL_CTRL);
    end

    // Bus next state
    always_comb begin
        wr_pend_next = addr_phase & hwrite;
        wr_sel_next  = addr_phase ? ap_sel : GP_SEL_NONE;
        rdata_next   = rdata_reg;
        if (addr_phase & ~hwrite) begin
            rdata_next = `GP_RDATA_RST;
        end
        // Read data reflects a write still in its data phase
        if (dir_reg_read_strobe) begin
            rdata_next[WIDTH-1:0] = dir_next; // RULE20
        end
        if (out_reg_read_strobe) begin
            rdata_next[WIDTH-1:0] = out_data_next; // RULE20
        end
        if (pin_read_strobe) begin
            rdata_next[WIDTH-1:0] = pin_input_next; // RULE7
        end
        if (ctrl_read_strobe) begin
            rdata_next[`GP_CTRL_PUD_BIT] = pud_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg  <= GP_SEL_NONE;
            rdata_reg   <= `GP_RDATA_RST;
        end else begin
            wr_pend_reg <= wr_pend_next; // RULE22
            wr_sel_reg  <= wr_sel_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Register next state
    always_comb begin
        dir_next      = dir_reg;
        out_data_next = out_data_reg;
        pud_next      = pud_reg;
        if (dir_reg_write_strobe) begin
            dir_next = wdata; // RULE1
        end
        if (out_reg_write_strobe) begin
            out_data_next = wdata;
        end
        if (in_reg_write_strobe) begin
            out_data_next = out_data_reg ^ wdata; // RULE6 RULE21
        end
        if (ctrl_write_strobe) begin
            pud_next = hwdata[`GP_CTRL_PUD_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_reg      <= `GP_DIR_RST; // RULE4
            out_data_reg <= `GP_OUT_RST; // RULE18
            pud_reg      <= `GP_PUD_RST;
        end else begin
            dir_reg      <= dir_next;
            out_data_reg <= out_data_next;
            pud_reg      <= pud_next;
        end
    end

    // Sleep clamp ahead of the input stage
    always_comb begin
        digital_in = pin_in & ~({WIDTH{sleep_clamp}} & ~(ext_int_enable | alt_input_enable)); // RULE14 RULE15 RULE16
    end

    // Synchronizer next state
    always_comb begin
        sync_latch_next = digital_in;
        pin_input_next  = sync_latch_reg;
    end

    // Latch stage closes at the falling edge
    always_ff @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_latch_reg <= '0;
        end else begin
            sync_latch_reg <= sync_latch_next; // RULE8 RULE9
        end
    end

    // Register stage loads at the rising edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_input_reg <= '0;
        end else begin
            pin_input_reg <= pin_input_next; // RULE8 RULE10
        end
    end

    // Pin drivers
    always_comb begin
        pin_oe    = dir_reg & {WIDTH{hresetn}}; // RULE1 RULE4
        pin_out   = out_data_reg; // RULE5
        pullup_en = ~dir_reg & out_data_reg & {WIDTH{~pud_reg & hresetn}}; // RULE2 RULE3 RULE18
    end

    // Outputs
    always_comb begin
        hrdata                = rdata_reg;
        hreadyout             = 1'b1; // RULE22
        hresp                 = `GP_HRESP_OKAY;
        pin_level             = pin_input_reg; // RULE17
        global_pullup_disable = pud_reg; // RULE19
    end

endmodule : gp_port

`default_nettype wire

// >>> dv/gp_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module gp_port_asserts #(parameter int WIDTH = 8) (
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic [31:0]      hwdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pullup_en,
    input wire logic             global_pullup_disable
);
    logic             dp;
    logic             dw;
    logic [7:0]       da;
    wire  [WIDTH-1:0] wd = hwdata[WIDTH-1:0];
    wire  [3:0]       wr = {4{dp & dw}} & {da == 8'h0c, da == 8'h08, da == 8'h04, da == 8'h00};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) {dp, dw, da} <= 10'h0;
        else {dp, dw, da} <= {hsel & hready & htrans[1], hwrite, haddr[7:0]};
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_dir_write: assert property (wr[0] |=> pin_oe == $past(wd))
        else $error("bad pin_oe");
    chk_dir_hold: assert property (!wr[0] |=> $stable(pin_oe))
        else $error("pin_oe moved");
    chk_out_write: assert property (wr[1] |=> pin_out == $past(wd))
        else $error("bad pin_out");
    chk_out_toggle: assert property (wr[2] |=> pin_out == ($past(pin_out) ^ $past(wd)))
        else $error("bad toggle");
    chk_pud_write: assert property (wr[3] |=> global_pullup_disable == $past(hwdata[0]))
        else $error("bad pud");
    chk_pullup_gate: assert property (pullup_en == (~pin_oe & pin_out & ~{WIDTH{global_pullup_disable}}))
        else $error("bad pullup");
    chk_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus stalled");
    chk_reset_float: assert property (disable iff (1'b0) !hresetn |-> !(|pin_oe) && !(|pullup_en))
        else $error("pins driven in reset");
    cover property (wr[2]);
    cover property (wr[3]);
    cover property (dp && !dw && da == 8'h08);
endmodule : gp_port_asserts
bind gp_port gp_port_asserts #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

// >>> dv/gp_board.sv
`timescale 1ns/1ns
`default_nettype none
module gp_board (
    input  wire logic       hclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] fl = 8'h5a;
    always_ff @(posedge hclk) fl <= ~fl;
    assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val | ~ext_en & (pullup_en | fl));
endmodule : gp_board
`default_nettype wire

// >>> dv/gp_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module gp_port_bench;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_clamp = 1'b0, rdp = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q[$];
    logic [7:0]  pin_in, pin_out, pin_oe, pullup_en, pin_level, d, o, t, ext_val = 8'h0, ext_en = 8'hff;
    logic [7:0]  ext_int_enable = 8'h0, alt_input_enable = 8'h0;
    wire         hready, hresp, global_pullup_disable;
    int          n_fail = 0, n_checks = 0;
    gp_port u_dut (.hsize(3'h2), .hreadyout(hready), .*);
    gp_board u_brd (.*);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %0t: got %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, v};
        if (!w) q.push_back({24'h0, v});
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : xfer
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    always @(posedge hclk) begin
        if (rdp) chk(hrdata, q.pop_front());
        rdp <= hsel & htrans[1] & ~hwrite & hready;
    end
    initial forever #4 hclk = ~hclk;
    initial begin
        #20000;
        n_fail++;
        test_done();
    end
    initial begin
        void'($urandom(32'h54f3));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, 8'h00, 8'h00);
        xfer(1'b0, 8'h0c, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            o = 8'($urandom);
            ext_en <= ~d & ~o;
            ext_val <= 8'($urandom);
            xfer(1'b1, 8'h00, 8'h00);
            xfer(1'b1, 8'h04, o);
            xfer(1'b1, 8'h00, d);
            @(negedge hclk);
            chk(32'(pin_oe), 32'(d));
            chk(32'(pin_out), 32'(o));
            chk(32'(pullup_en), 32'(~d & o));
            @(posedge hclk);
            xfer(1'b0, 8'h08, o | ~d & ext_val);
            t = 8'($urandom);
            xfer(1'b1, 8'h08, t);
            o = o ^ t;
            xfer(1'b0, 8'h04, o);
            xfer(1'b0, 8'h00, d);
        end
        ext_en <= ~d & ~o;
        xfer(1'b1, 8'h0c, 8'h01);
        @(negedge hclk);
        chk(32'(pullup_en), 32'h0);
        @(posedge hclk);
        xfer(1'b0, 8'h0c, 8'h01);
        xfer(1'b1, 8'h0c, 8'h00);
        t = 8'($urandom);
        ext_int_enable <= t;
        alt_input_enable <= ~t & 8'h0f;
        sleep_clamp <= 1'b1;
        repeat (2) @(posedge hclk);
        xfer(1'b0, 8'h08, (o | ~d & ext_val) & (t | 8'h0f));
        sleep_clamp <= 1'b0;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk(32'(pin_level), 32'(o | ~d & ext_val));
        @(posedge hclk);
        xfer(1'b1, 8'h10, 8'hff);
        xfer(1'b0, 8'h10, 8'h00);
        hresetn <= 1'b0;
        #1;
        chk(32'(pin_oe), 32'h0);
        chk(32'(pullup_en), 32'h0);
        test_done();
    end
endmodule : gp_port_bench
`default_nettype wire
